/* hdl/cio_port_block.sv */
// Seven configurable I/O ports with output mux, drive enable, read-back and capture
//
// Operation
// RQ1: Seven ports A to G, eight pins each, Port D only four.
// RQ2: Each pin configured on its own, by programming or host register writes.
// RQ3: A pin assigned one function serves no other, noted exceptions aside.
// RQ4: Output mux selects data-out, latched address, macrocell or chip select.
// RQ5: Read-back buffer passes exactly one selected source to the host.
// RQ6: Driver enable is enable product term OR direction bit.
// RQ7: Without product term or logic output, direction bit alone enables driver.
// RQ8: Ports A to C have capture cells: latch, edge register or pass-through.
// RQ9: Capture clocked by address latch strobe or a logic-array product term.
// RQ10: Capture outputs feed the logic-array input bus and are host readable.
// RQ11: Programmed modes fixed until reprogramming; others change at run time.
// RQ12: Host I/O everywhere; macrocell banks on A and B; logic inputs A-D, F (only A to C capture outputs reach o_logic_in here).
// RQ13: Address-out on E, F, G; data port on F, G; peripheral on F.
// RQ14: Extra chip-select outputs route only to Port C and Port F.
// RQ15: Data port: Port F carries D0-7, Port G carries D8-15.
// RQ16: Control bit zero on E, F, G puts pin in host I/O mode.
// RQ17: Latched address drives only on product term or direction and control set.
// RQ18: Peripheral I/O on Port F enabled by memory-map control bit seven.
// RQ19: Data port mode on F and G disables their general-purpose I/O.
module cio_port_block #(
  parameter logic [6:0][7:0] LOGIC_OUT_MASK = '0,
  parameter logic [6:0][7:0] OE_PT_MASK = '0,
  parameter logic [6:0][7:0] ECS_MASK = '0,
  parameter logic [23:0][1:0] CAP_MODE = '0,
  parameter logic [5:0] CAP_CLK_PT = '0,
  parameter bit DATA_PORT_EN = 1'b0,
  parameter bit PERIPH_EN = 1'b0,
  parameter bit ADDR_G_HIGH = 1'b0
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Host register access
  input wire cio_pkg::cio_host_wr_t i_host_wr,
  input wire logic [2:0] i_rb_port,
  input wire cio_pkg::cio_rb_t i_rb_src,
  input wire logic [7:0] i_memmap_ctrl,
  // Logic array
  input wire logic [7:0] i_mcell_a,
  input wire logic [7:0] i_mcell_b,
  input wire logic [7:0] i_ecs,
  input wire logic [6:0][7:0] i_oe_pt,
  input wire logic [5:0] i_capture_pt,
  // Host bus side
  input wire logic [15:0] i_lat_addr,
  input wire logic i_addr_latch_strobe,
  input wire logic [15:0] i_bus_data,
  input wire logic i_bus_data_oe,
  input wire logic [7:0] i_periph_data,
  input wire logic i_periph_oe,
  // Pins
  input wire logic [6:0][7:0] i_pin,
  output cio_pkg::cio_drive_t [6:0] o_pin,
  // Results
  output logic [7:0] o_readback,
  output logic [23:0] o_logic_in,
  output logic [15:0] o_bus_data,
  output logic [7:0] o_periph_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks on the programmed configuration

  // Macrocell outputs only on A and B, chip selects only on C and F
  if ((LOGIC_OUT_MASK[2] | LOGIC_OUT_MASK[3] | LOGIC_OUT_MASK[4] | LOGIC_OUT_MASK[5]
       | LOGIC_OUT_MASK[6]) != 8'h00) begin : g_bad_mcell // [RQ12]
    $error("macrocell outputs allowed on ports A and B only");
  end
  if ((ECS_MASK[0] | ECS_MASK[1] | ECS_MASK[3] | ECS_MASK[4]
       | ECS_MASK[6]) != 8'h00) begin : g_bad_ecs // [RQ14]
    $error("chip-select outputs allowed on ports C and F only");
  end
  // A pin carries one programmed function
  if (DATA_PORT_EN && (PERIPH_EN || ECS_MASK[5] != 8'h00)) begin : g_bad_f // [RQ3]
    $error("port F cannot be data port and carry another function");
  end
  if ((LOGIC_OUT_MASK[3] | OE_PT_MASK[3] | ECS_MASK[3]) > 8'h0f) begin : g_bad_d // [RQ1]
    $error("port D has four pins only");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper decodes

  // Pins present on a port
  function automatic logic [7:0] port_mask(input int p);
    port_mask = (p == 3) ? cio_pkg::MASK_NIBBLE : cio_pkg::MASK_FULL; // [RQ1]
  endfunction

  // Port carries a control register
  function automatic logic has_ctrl(input int p);
    has_ctrl = (p >= 4); // [RQ4]
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  logic [6:0][7:0] pin_s;
  logic strobe_s;
  cio_sync #(.W(56)) u_pin_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_async(i_pin),
    .o_sync(pin_s)
  );
  cio_sync #(.W(1)) u_strobe_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_async(i_addr_latch_strobe),
    .o_sync(strobe_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Host registers: data out, direction, control
  logic [6:0][7:0] data_q, data_d;
  logic [6:0][7:0] dir_q, dir_d;
  logic [6:0][7:0] ctrl_q, ctrl_d;
  // Whole port byte written at once, masked to the pins present; control ignored on A to D
  always_comb begin
    data_d = data_q;
    dir_d = dir_q;
    ctrl_d = ctrl_q;
    if (i_host_wr.valid && i_host_wr.port < 3'h7) begin // [RQ2]
      unique case (i_host_wr.reg_sel)
        cio_pkg::CIO_REG_DATA: begin
          data_d[i_host_wr.port] = i_host_wr.data & port_mask(int'(i_host_wr.port));
        end
        cio_pkg::CIO_REG_DIR: begin
          dir_d[i_host_wr.port] = i_host_wr.data & port_mask(int'(i_host_wr.port));
        end
        cio_pkg::CIO_REG_CTRL: begin
          if (has_ctrl(int'(i_host_wr.port))) begin // [RQ11]
            ctrl_d[i_host_wr.port] = i_host_wr.data;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      data_q <= {7{cio_pkg::DATA_RST}};
      dir_q <= {7{cio_pkg::DIR_RST}};
      ctrl_q <= {7{cio_pkg::CTRL_RST}};
    end else begin
      data_q <= data_d;
      dir_q <= dir_d;
      ctrl_q <= ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input capture cells on ports A to C
  logic [5:0] cap_level;
  logic [5:0] cap_prev_q, cap_prev_d;
  logic [5:0] cap_edge;
  logic [23:0] cap_val;
  // Capture clock per nibble: address strobe or product term
  always_comb begin
    for (int g = 0; g < 6; g++) begin
      cap_level[g] = CAP_CLK_PT[g] ? i_capture_pt[g] : strobe_s; // [RQ9]
      cap_edge[g] = cap_level[g] & ~cap_prev_q[g];
    end
    cap_prev_d = cap_level;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cap_prev_q <= '0;
    end else begin
      cap_prev_q <= cap_prev_d;
    end
  end

  for (genvar c = 0; c < 24; c++) begin : g_cap
    cio_capture_cell #(
      .MODE(cio_pkg::cio_cap_t'(CAP_MODE[c]))
    ) u_cell ( // [RQ8]
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_level(cap_level[c/4]),
      .i_edge(cap_edge[c/4]),
      .i_pin(pin_s[c/8][c%8]),
      .o_val(cap_val[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output mux and driver enable per pin

  cio_pkg::cio_drive_t [6:0] drive_q, drive_d;
  logic periph_on;
  logic [7:0] addr_src;
  // Programmed modes first, run-time host modes below them
  always_comb begin
    periph_on = PERIPH_EN && i_memmap_ctrl[cio_pkg::MEMMAP_PERIPH_BIT]; // [RQ18]
    drive_d = '0;
    addr_src = 8'h00;
    for (int p = 0; p < 7; p++) begin
      for (int b = 0; b < 8; b++) begin
        // Host I/O default, driver enable is product term OR direction
        drive_d[p].out[b] = data_q[p][b]; // [RQ16]
        drive_d[p].oe[b] = (OE_PT_MASK[p][b] & i_oe_pt[p][b]) | dir_q[p][b]; // [RQ6] [RQ7]
        if (LOGIC_OUT_MASK[p][b]) begin
          drive_d[p].out[b] = (p == 0) ? i_mcell_a[b] : i_mcell_b[b]; // [RQ12] [RQ4]
        end else if (ECS_MASK[p][b]) begin
          drive_d[p].out[b] = i_ecs[b]; // [RQ14]
        end else if (has_ctrl(p) && ctrl_q[p][b]) begin
          addr_src = (p == 6 && ADDR_G_HIGH) ? i_lat_addr[15:8] : i_lat_addr[7:0];
          drive_d[p].out[b] = addr_src[b]; // [RQ13]
          // Only product term or direction with control both set
          drive_d[p].oe[b] = (OE_PT_MASK[p][b] & i_oe_pt[p][b])
                             | (dir_q[p][b] & ctrl_q[p][b]); // [RQ17]
        end
        if (p == 5 && periph_on) begin
          drive_d[p].out[b] = i_periph_data[b]; // [RQ13]
          drive_d[p].oe[b] = i_periph_oe;
        end
        if ((p == 5 || p == 6) && DATA_PORT_EN) begin
          // General I/O is cut off while the port is the data bus
          drive_d[p].out[b] = (p == 5) ? i_bus_data[b] : i_bus_data[8+b]; // [RQ15] [RQ19]
          drive_d[p].oe[b] = i_bus_data_oe;
        end
      end
      drive_d[p].out = drive_d[p].out & port_mask(p); // [RQ1]
      drive_d[p].oe = drive_d[p].oe & port_mask(p);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      drive_q <= '0;
    end else begin
      drive_q <= drive_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back, capture bus and data returned to the host

  logic [7:0] rb_q, rb_d;
  logic [23:0] logic_in_q, logic_in_d;
  logic [15:0] bus_q, bus_d;
  logic [7:0] periph_q, periph_d;
  // One source passes at a time; absent sources read as zero
  always_comb begin
    rb_d = 8'h00;
    if (i_rb_port < 3'h7) begin
      unique case (i_rb_src)
        cio_pkg::CIO_RB_DATA: rb_d = data_q[i_rb_port]; // [RQ5]
        cio_pkg::CIO_RB_MCELL: begin
          rb_d = (i_rb_port == cio_pkg::PORT_A) ? i_mcell_a :
                 (i_rb_port == cio_pkg::PORT_B) ? i_mcell_b : 8'h00;
        end
        cio_pkg::CIO_RB_DIR: rb_d = dir_q[i_rb_port];
        cio_pkg::CIO_RB_CTRL: rb_d = ctrl_q[i_rb_port];
        cio_pkg::CIO_RB_PIN: rb_d = pin_s[i_rb_port] & port_mask(int'(i_rb_port));
        cio_pkg::CIO_RB_CAPTURE: begin
          rb_d = (i_rb_port <= cio_pkg::PORT_C) ? cap_val[i_rb_port*8 +: 8] : 8'h00; // [RQ10]
        end
        default: rb_d = 8'h00;
      endcase
    end
    logic_in_d = cap_val; // [RQ10]
    bus_d = DATA_PORT_EN ? {pin_s[6], pin_s[5]} : 16'h0000; // [RQ15]
    periph_d = periph_on ? pin_s[5] : 8'h00;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rb_q <= 8'h00;
      logic_in_q <= 24'h000000;
      bus_q <= 16'h0000;
      periph_q <= 8'h00;
    end else begin
      rb_q <= rb_d;
      logic_in_q <= logic_in_d;
      bus_q <= bus_d;
      periph_q <= periph_d;
    end
  end

  assign o_pin = drive_q;
  assign o_readback = rb_q;
  assign o_logic_in = logic_in_q;
  assign o_bus_data = bus_q;
  assign o_periph_data = periph_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  port_d_upper_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [RQ1]
    (o_pin[3].out[7:4] == 4'h0) && (o_pin[3].oe[7:4] == 4'h0))
    else $error("port D upper pins driven");

  ctrl_only_efg_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [RQ11]
    ctrl_q[3:0] == 32'h00000000)
    else $error("control bits set on a port without control register");

  host_write_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [RQ2]
    i_host_wr.valid && i_host_wr.reg_sel == cio_pkg::CIO_REG_DIR && i_host_wr.port == 3'h0
    |=> dir_q[0] == $past(i_host_wr.data))
    else $error("direction write to port A not stored");

  dir_alone_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [RQ7]
    (OE_PT_MASK[0][0] == 1'b0 && LOGIC_OUT_MASK[0][0] == 1'b0)
    |=> o_pin[0].oe[0] == $past(dir_q[0][0]))
    else $error("host pin enable does not follow direction bit");

  host_io_out_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [RQ16]
    (!DATA_PORT_EN && ctrl_q[4][0] == 1'b0 && LOGIC_OUT_MASK[4][0] == 1'b0)
    |=> o_pin[4].out[0] == $past(data_q[4][0]))
    else $error("port E pin with control zero not in host I/O");

  addr_out_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [RQ17]
    (ctrl_q[4][7] && !dir_q[4][7] && !(OE_PT_MASK[4][7] && i_oe_pt[4][7]))
    |=> !o_pin[4].oe[7])
    else $error("latched address driven without enable");

  data_port_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [RQ19]
    DATA_PORT_EN |=> o_pin[6].oe == {8{$past(i_bus_data_oe)}}
                     && o_pin[6].out == $past(i_bus_data[15:8]))
    else $error("port G not following host data bus");

  readback_dir_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [RQ5]
    i_rb_src == cio_pkg::CIO_RB_DIR && i_rb_port == cio_pkg::PORT_E
    |=> o_readback == $past(dir_q[4]))
    else $error("read-back does not return direction register");

  capture_bus_a: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [RQ10]
    cio_pkg::cio_cap_t'(CAP_MODE[0]) == cio_pkg::CIO_CAP_PASS
    |=> o_logic_in[0] == $past(pin_s[0][0]))
    else $error("pass-through capture not on logic input bus");

endmodule // cio_port_block

/* include/cio_pkg.sv */
// Shared constants and carrier types for the configurable I/O port block
package cio_pkg;

  // Port geometry
  localparam int NUM_PORTS = 7;
  localparam int PORT_W = 8;
  localparam int PORT_D_W = 4;
  localparam int CAP_PORTS = 3;
  localparam int CAP_CELLS = CAP_PORTS * PORT_W;
  localparam int CAP_GROUPS = CAP_CELLS / 4;
  localparam int ADDR_W = 16;
  localparam int BUS_W = 16;

  // Port indices
  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_B = 3'h1;
  localparam logic [2:0] PORT_C = 3'h2;
  localparam logic [2:0] PORT_D = 3'h3;
  localparam logic [2:0] PORT_E = 3'h4;
  localparam logic [2:0] PORT_F = 3'h5;
  localparam logic [2:0] PORT_G = 3'h6;

  // Pin masks per port width
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_NIBBLE = 8'h0f;

  // Memory-map control field
  localparam int MEMMAP_PERIPH_BIT = 7;

  // Values after reset
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Host register select
  typedef enum logic [1:0] {
    CIO_REG_DATA = 2'h0,
    CIO_REG_DIR = 2'h1,
    CIO_REG_CTRL = 2'h2
  } cio_reg_t;

  // Read-back source select
  typedef enum logic [2:0] {
    CIO_RB_DATA = 3'h0,
    CIO_RB_MCELL = 3'h1,
    CIO_RB_DIR = 3'h2,
    CIO_RB_CTRL = 3'h3,
    CIO_RB_PIN = 3'h4,
    CIO_RB_CAPTURE = 3'h5
  } cio_rb_t;

  // Capture cell modes
  typedef enum logic [1:0] {
    CIO_CAP_PASS = 2'h0,
    CIO_CAP_LATCH = 2'h1,
    CIO_CAP_REG = 2'h2
  } cio_cap_t;

  // Host register write request
  typedef struct packed {
    logic valid;
    logic [2:0] port;
    cio_reg_t reg_sel;
    logic [7:0] data;
  } cio_host_wr_t;

  // Drive of one port: value and enable per pin
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } cio_drive_t;

endpackage

/* hdl/cio_sync.sv */
// Two-stage synchroniser for pin-side levels
module cio_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Data
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule // cio_sync

/* hdl/cio_capture_cell.sv */
// One input capture cell: pass-through, transparent latch or edge register
module cio_capture_cell #(
  parameter cio_pkg::cio_cap_t MODE = cio_pkg::CIO_CAP_PASS
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Capture control
  input wire logic i_level,
  input wire logic i_edge,
  // Data
  input wire logic i_pin,
  output logic o_val
);

  logic held_q;
  logic held_d;

  // Next held value
  always_comb begin
    held_d = held_q;
    if (MODE == cio_pkg::CIO_CAP_LATCH && i_level) begin
      held_d = i_pin;
    end
    if (MODE == cio_pkg::CIO_CAP_REG && i_edge) begin
      held_d = i_pin;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      held_q <= 1'b0;
    end else begin
      held_q <= held_d;
    end
  end

  // Latch is transparent while its enable is high
  assign o_val = (MODE == cio_pkg::CIO_CAP_PASS) ? i_pin :
                 (MODE == cio_pkg::CIO_CAP_LATCH && i_level) ? i_pin : held_q;

endmodule // cio_capture_cell

/* testbench/cio_pin_model.sv */
// Far-side model of the port pins: block drive against outside sources
module cio_pin_model (
  // Block drive
  input wire cio_pkg::cio_drive_t [6:0] i_drive,
  // Outside sources, seen wherever the block does not drive
  input wire logic [6:0][7:0] i_ext,
  // Resolved pin levels
  output logic [6:0][7:0] o_level
);
  timeunit 1ns;
  timeprecision 1ps;
  //////////////////////////////////////////////////////////////////////////////
  // Block wins per pin where its enable is high; no contention is modelled
  always_comb begin
    for (int p = 0; p < 7; p++) begin
      o_level[p] = (i_drive[p].out & i_drive[p].oe) | (i_ext[p] & ~i_drive[p].oe);
    end
  end
endmodule // cio_pin_model

/* testbench/tb_top.sv */
// Self-checking bench for the configurable I/O port block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0] port;
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] out;
    logic [7:0] oe;
  } cio_row_t;
  logic clk, rst, strobe, bus_oe, periph_oe;
  cio_pkg::cio_host_wr_t host_wr;
  logic [2:0] rb_port;
  cio_pkg::cio_rb_t rb_src;
  logic [7:0] memmap, mcell_a, mcell_b, ecs, periph_data, readback, periph_q, msk;
  logic [6:0][7:0] oe_pt, ext, lvl;
  logic [5:0] cap_pt;
  logic [15:0] lat_addr, bus_data, bus_q, bus_dp;
  logic [23:0] logic_in;
  cio_pkg::cio_drive_t [6:0] pins, pins_dp;
  int failures, num_checks, cycles;
  // Host-mode rows: port, data, direction, expected pin value and enable
  cio_row_t rows [7] = '{'{3'h0, 8'h5a, 8'h0f, 8'h3a, 8'h0f}, '{3'h1, 8'ha5, 8'hff, 8'ha5, 8'hff},
    '{3'h2, 8'h00, 8'hf0, 8'h09, 8'hf0}, '{3'h3, 8'hff, 8'hff, 8'h0f, 8'h0f},
    '{3'h4, 8'h81, 8'h7e, 8'h81, 8'h7e}, '{3'h5, 8'h3c, 8'hc3, 8'h3c, 8'hc3},
    '{3'h6, 8'he7, 8'h18, 8'he7, 8'h18}};
  //////////////////////////////////////////////////////////////////////////////
  // A macrocell on A7-4, chip selects on C3-0, product-term enables on A7-4 and E3-0
  cio_port_block #(.LOGIC_OUT_MASK(56'hf0), .OE_PT_MASK(56'h0f_0000_00f0),
    .ECS_MASK(56'h0f_0000), .CAP_MODE(48'h55_aa00), .CAP_CLK_PT(6'h04),
    .DATA_PORT_EN(1'b0), .PERIPH_EN(1'b1), .ADDR_G_HIGH(1'b1)) cio_port_block_i (
    .i_ref_clk(clk), .i_reset(rst), .i_host_wr(host_wr), .i_rb_port(rb_port),
    .i_rb_src(rb_src), .i_memmap_ctrl(memmap), .i_mcell_a(mcell_a), .i_mcell_b(mcell_b),
    .i_ecs(ecs), .i_oe_pt(oe_pt), .i_capture_pt(cap_pt), .i_lat_addr(lat_addr),
    .i_addr_latch_strobe(strobe), .i_bus_data(bus_data), .i_bus_data_oe(bus_oe),
    .i_periph_data(periph_data), .i_periph_oe(periph_oe), .i_pin(lvl), .o_pin(pins),
    .o_readback(readback), .o_logic_in(logic_in), .o_bus_data(bus_q),
    .o_periph_data(periph_q));
  cio_pin_model cio_pin_model_i (.i_drive(pins), .i_ext(ext), .o_level(lvl));
  // Second copy as the non-multiplexed data port; its pins see outside sources only
  if (1'b1) begin : g_dp
    cio_port_block #(.DATA_PORT_EN(1'b1)) cio_port_block_i (
      .i_ref_clk(clk), .i_reset(rst), .i_host_wr(host_wr), .i_rb_port(rb_port),
      .i_rb_src(rb_src), .i_memmap_ctrl(memmap), .i_mcell_a(mcell_a), .i_mcell_b(mcell_b),
      .i_ecs(ecs), .i_oe_pt(oe_pt), .i_capture_pt(cap_pt), .i_lat_addr(lat_addr),
      .i_addr_latch_strobe(strobe), .i_bus_data(bus_data), .i_bus_data_oe(bus_oe),
      .i_periph_data(periph_data), .i_periph_oe(periph_oe), .i_pin(ext), .o_pin(pins_dp),
      .o_readback(), .o_logic_in(), .o_bus_data(bus_dp), .o_periph_data());
  end
  //////////////////////////////////////////////////////////////////////////////
  // Clock at 4 ns, plus a cycle ceiling so a hang still reports
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Shared tasks; compares land at the falling edge, clear of register updates
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // One-cycle write pulse, dropped on the next edge
  task automatic wr(input logic [2:0] p, input cio_pkg::cio_reg_t r, input logic [7:0] d);
    @(posedge clk);
    host_wr <= '{valid: 1'b1, port: p, reg_sel: r, data: d};
    @(posedge clk);
    host_wr.valid <= 1'b0;
  endtask
  task automatic rb(input logic [2:0] p, input cio_pkg::cio_rb_t s, input logic [7:0] e);
    @(posedge clk);
    rb_port <= p;
    rb_src <= s;
    settle(3);
    chk(readback, e);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1; strobe = 1'b0; bus_oe = 1'b0; periph_oe = 1'b0; host_wr = '0;
    rb_port = 3'h0; rb_src = cio_pkg::CIO_RB_DATA; memmap = 8'h00; mcell_a = 8'h3c;
    mcell_b = 8'hc3; ecs = 8'h09; periph_data = 8'ha5; oe_pt = '0; ext = {7{8'h66}};
    cap_pt = 6'h00; lat_addr = 16'hbeef; bus_data = 16'h0000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    chk(pins[6], 24'h0);
    chk(readback, 24'h0);
    foreach (rows[i]) begin
      msk = (rows[i].port == cio_pkg::PORT_D) ? cio_pkg::MASK_NIBBLE : cio_pkg::MASK_FULL;
      wr(rows[i].port, cio_pkg::CIO_REG_DATA, rows[i].data);
      wr(rows[i].port, cio_pkg::CIO_REG_DIR, rows[i].dir);
      settle(3);
      chk(pins[rows[i].port].out, rows[i].out);
      chk(pins[rows[i].port].oe, rows[i].oe);
      rb(rows[i].port, cio_pkg::CIO_RB_DATA, rows[i].data & msk);
      rb(rows[i].port, cio_pkg::CIO_RB_DIR, rows[i].dir & msk);
      rb(rows[i].port, cio_pkg::CIO_RB_PIN,
         ((rows[i].out & rows[i].oe) | (8'h66 & ~rows[i].oe)) & msk);
    end
    rb(3'h0, cio_pkg::CIO_RB_MCELL, 8'h3c);
    rb(3'h1, cio_pkg::CIO_RB_MCELL, 8'hc3);
    rb(3'h2, cio_pkg::CIO_RB_MCELL, 8'h00);
    // Macrocell and chip-select sources must follow their inputs
    @(posedge clk);
    mcell_a <= 8'hc5;
    ecs <= 8'h06;
    settle(3);
    chk(pins[0].out, 8'hca);
    chk(pins[2].out, 8'h06);
    wr(3'h7, cio_pkg::CIO_REG_DATA, 8'hff);
    rb(3'h7, cio_pkg::CIO_RB_DATA, 8'h00);
    // Address out on E, then product term, then back to host mode
    wr(3'h4, cio_pkg::CIO_REG_CTRL, 8'hff);
    settle(3);
    chk(pins[4], 16'hef7e);
    @(posedge clk);
    oe_pt <= {56'h81_00ff_00ff_ffff};
    settle(3);
    chk(pins[4].oe, 8'h7f);
    chk(pins[0].oe, 8'hff);
    chk(pins[2].oe, 8'hf0);
    rb(3'h4, cio_pkg::CIO_RB_CTRL, 8'hff);
    wr(3'h4, cio_pkg::CIO_REG_CTRL, 8'h00);
    wr(3'h6, cio_pkg::CIO_REG_CTRL, 8'hff);
    wr(3'h6, cio_pkg::CIO_REG_DIR, 8'hff);
    settle(3);
    chk(pins[4].out, 8'h81);
    chk(pins[6], 16'hbeff);
    @(posedge clk);
    lat_addr <= 16'h12c3;
    settle(3);
    chk(pins[6].out, 8'h12);
    wr(3'h0, cio_pkg::CIO_REG_CTRL, 8'hff);
    rb(3'h0, cio_pkg::CIO_RB_CTRL, 8'h00);
    // Peripheral mode only on bit seven of memory-map control
    @(posedge clk);
    memmap <= 8'h40;
    periph_oe <= 1'b1;
    settle(3);
    chk(pins[5].out, 8'h3c);
    @(posedge clk);
    memmap <= 8'h80;
    settle(5);
    chk(pins[5], 16'ha5ff);
    chk(periph_q, 8'ha5);
    @(posedge clk);
    periph_data <= 8'h5c;
    settle(3);
    chk(pins[5].out, 8'h5c);
    @(posedge clk);
    periph_oe <= 1'b0;
    settle(5);
    chk(pins[5].oe, 8'h00);
    chk(periph_q, 8'h66);
    chk(bus_q, 16'h0000);
    // Reset in mid-run clears the registers
    @(posedge clk);
    rst <= 1'b1;
    memmap <= 8'h00;
    oe_pt <= '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    chk(pins[6], 16'h0000);
    rb(3'h6, cio_pkg::CIO_RB_DIR, 8'h00);
    // Capture cells: pass on A3-0, strobe register on A7-4, term latch on B3-0
    @(posedge clk);
    ext[0] <= 8'ha5;
    ext[1] <= 8'hff;
    settle(5);
    chk(logic_in, 24'h66f005);
    @(posedge clk);
    strobe <= 1'b1;
    cap_pt[2] <= 1'b1;
    settle(4);
    chk(logic_in, 24'h66ffa5);
    @(posedge clk);
    strobe <= 1'b0;
    cap_pt[2] <= 1'b0;
    settle(2);
    @(posedge clk);
    ext[0] <= 8'h5a;
    ext[1] <= 8'h00;
    settle(5);
    chk(logic_in, 24'h660faa);
    rb(3'h0, cio_pkg::CIO_RB_CAPTURE, 8'haa);
    rb(3'h3, cio_pkg::CIO_RB_CAPTURE, 8'h00);
    // Data port copy: F and G follow the host bus, direction bits cut off
    wr(3'h5, cio_pkg::CIO_REG_DIR, 8'hff);
    @(posedge clk);
    bus_data <= 16'h1234;
    settle(3);
    chk(pins_dp[5], 16'h3400);
    chk(bus_dp, 16'h6666);
    @(posedge clk);
    bus_oe <= 1'b1;
    settle(3);
    chk(pins_dp[5], 16'h34ff);
    chk(pins_dp[6], 16'h12ff);
    print_verdict();
  end
endmodule // tb_top
